/* File: verilog/iocfg_regs.svh */
// register offsets, reset values and timing figures of the i/o configuration register bank
`ifndef IOCFG_REGS_SVH
`define IOCFG_REGS_SVH

`define IOCFG_ADDR_VERSION 16'h0000
`define IOCFG_ADDR_SWITCH 16'h0001
`define IOCFG_ADDR_RATE 16'h0002
`define IOCFG_ADDR_FRAMING 16'h0003
`define IOCFG_ADDR_PARITY 16'h0004
`define IOCFG_ADDR_HOLDOFF 16'h0005
`define IOCFG_ADDR_PROTO 16'h0006
`define IOCFG_ADDR_TIMEOUT 16'h0008
`define IOCFG_ADDR_FALLBACK 16'h000C
`define IOCFG_ADDR_DEBOUNCE 16'h0011
`define IOCFG_ADDR_RX_LO 16'h0020
`define IOCFG_ADDR_RX_HI 16'h0021
`define IOCFG_ADDR_BAD_LO 16'h0022
`define IOCFG_ADDR_BAD_HI 16'h0023
`define IOCFG_ADDR_TX_LO 16'h0024
`define IOCFG_ADDR_TX_HI 16'h0025
`define IOCFG_ADDR_INPUTS 16'h0032
`define IOCFG_ADDR_OUTPUTS 16'h0033
`define IOCFG_ADDR_PULSE1_LO 16'h0034

// framing register: stop bits in bits 7:0, data bits in bits 15:8
`define IOCFG_FR_STOP_LSB 0
`define IOCFG_FR_DATA_LSB 8

`define IOCFG_DEF_RATE 16'h0003
`define IOCFG_DEF_FRAMING 16'h0801
`define IOCFG_DEF_PARITY 16'h0000
`define IOCFG_DEF_HOLDOFF 16'h0000
`define IOCFG_DEF_PROTO 16'h0000
`define IOCFG_DEF_TIMEOUT 16'h0000
`define IOCFG_DEF_FALLBACK 16'h0000
`define IOCFG_DEF_DEBOUNCE 16'h0000

`define IOCFG_CLK_HZ 40000000
`define IOCFG_MS_PER_S 1000
`define IOCFG_CYC_PER_MS (`IOCFG_CLK_HZ / `IOCFG_MS_PER_S)
`define IOCFG_FILT_RISE_MS 40
`define IOCFG_FILT_FALL_MS 80
`define IOCFG_LED_ON_MS 50
`define IOCFG_RESTORE_CHK 5

`endif

/* File: verilog/iocfg_pkg.sv */
// types of the i/o configuration register bank
package iocfg_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } iocfg_req_t;

    typedef struct packed {
        logic rx_ok;
        logic rx_bad;
        logic tx_done;
        logic reply_ready;
    } iocfg_pkt_t;

    typedef struct packed {
        logic [7:0] sa1;
        logic [7:0] sa2;
        logic [7:0] sa3;
        logic [5:0] sw1;
        logic [5:0] sw2;
        logic [5:0] sw3;
        logic [7:0] din_stable;
        logic [5:0] sw_stable;
        logic [7:0] filt;
        logic [7:0][6:0] dbc_cnt;
        logic [15:0] ms_pre;
        logic ms_tick;
        logic [15:0] rate_code;
        logic [15:0] framing;
        logic [15:0] parity;
        logic [15:0] holdoff;
        logic [15:0] proto;
        logic [15:0] timeout;
        logic [15:0] fallback;
        logic [15:0] debounce_en;
        logic [31:0] rx_cnt;
        logic [31:0] bad_cnt;
        logic [31:0] tx_cnt;
        logic [15:0] pulse1_lo;
        logic [15:0] outs;
        logic [15:0] wd_cnt;
        logic wd_fire;
        logic hold_busy;
        logic [15:0] hold_ms;
        logic [15:0] hold_sub;
        logic tx_start;
        logic awaiting;
        logic [9:0] led_cnt;
        logic comm_led;
        logic [19:0] baud_hz;
        logic two_stop;
        logic seven_bits;
        logic [15:0] rdata;
        logic ack;
        logic err;
        logic [2:0] chk;
        logic restore_done;
    } iocfg_state_t;

endpackage

/* File: verilog/iocfg_regbank.sv */
// configuration and status register bank of an eight-in eight-out serial expansion module
// Notes on behaviour
// [RULE1] operator restores defaults: power off, restore switch on, power on, switch off
// [RULE2] a restore clears every register value and reloads the default line setup
// [RULE3] rate codes 0..6 pick 2400..115200 baud; other codes mean value times ten
// [RULE4] parity code: 0 none, 1 odd, 2 even, 3 forced zero, 4 forced one
// [RULE5] one register holds stop bits (1 or 2) and data bits (7 or 8)
// [RULE6] each reply is held off by the programmed number of milliseconds
// [RULE7] protocol mode 0 selects binary framing, 1 selects character framing
// [RULE8] no valid message within the timeout drives all outputs to fallback state
// [RULE9] a timeout of zero disables the watchdog; it resets to zero
// [RULE10] comm indicator lights only after a good packet and its sent reply; the code also lights it after a restore while the restore switch stays on
// [RULE11] input indicators follow high inputs, output indicators follow switched-on outputs
// [RULE12] bus address 0..31 comes from switches one to five weighted 1..16
// [RULE13] filtered input rises after 40 ms of voltage, falls after 80 ms without
// [RULE14] filtering is enabled per input through the debounce enable register
// [RULE15] fallback pattern drives the outputs after power-up and after a timeout
// [RULE16] received, bad and sent packets counted as 32 bits in low/high words
// [RULE17] read-only offset zero reports version and type identification
// [RULE18] all registers are 16 bits, reached by binary or character protocol
// [RULE19] bit n of per-channel registers belongs to channel n+1
// [RULE20] every valid message restarts the watchdog from its full value
// [RULE21] switch register shows all six switches, bit k for switch k+1
`include "iocfg_regs.svh"

module iocfg_regbank #(
    // arbitrary identification value
    parameter logic [15:0] VERSION_TYPE_ID = 16'h0A01,
    parameter logic [15:0] CYC_PER_MS = 16'(`IOCFG_CYC_PER_MS),
    parameter logic [6:0] FILT_RISE_MS = 7'(`IOCFG_FILT_RISE_MS),
    parameter logic [6:0] FILT_FALL_MS = 7'(`IOCFG_FILT_FALL_MS),
    parameter logic [9:0] LED_ON_MS = 10'(`IOCFG_LED_ON_MS)
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire iocfg_pkg::iocfg_req_t i_req,
    input wire iocfg_pkg::iocfg_pkt_t i_pkt,
    input wire logic [7:0] i_din,
    input wire logic [5:0] i_switch,
    output logic o_reg_ack,
    output logic o_reg_err,
    output logic [15:0] o_reg_rdata,
    output logic [7:0] o_dout,
    output logic [7:0] o_in_led,
    output logic [7:0] o_out_led,
    output logic o_comm_led,
    output logic [4:0] o_module_addr,
    output logic [19:0] o_baud_hz,
    output logic [2:0] o_parity_mode,
    output logic o_two_stop,
    output logic o_seven_bits,
    output logic o_ascii_mode,
    output logic o_tx_start,
    output logic o_restore_active
);

    iocfg_pkg::iocfg_state_t st;
    iocfg_pkg::iocfg_state_t n;

    function automatic logic [19:0] rate_of(input logic [15:0] code);
        unique case (code)
            16'h0000: rate_of = 20'd2400;
            16'h0001: rate_of = 20'd4800;
            16'h0002: rate_of = 20'd9600;
            16'h0003: rate_of = 20'd19200;
            16'h0004: rate_of = 20'd38400;
            16'h0005: rate_of = 20'd57600;
            16'h0006: rate_of = 20'd115200;
            default: rate_of = 20'(code) * 20'd10;
        endcase
    endfunction

    function automatic iocfg_pkg::iocfg_state_t clear_regs(input iocfg_pkg::iocfg_state_t s);
        iocfg_pkg::iocfg_state_t r;
        r = s;
        r.rate_code = `IOCFG_DEF_RATE;
        r.framing = `IOCFG_DEF_FRAMING;
        r.parity = `IOCFG_DEF_PARITY;
        r.holdoff = `IOCFG_DEF_HOLDOFF;
        r.proto = `IOCFG_DEF_PROTO;
        r.timeout = `IOCFG_DEF_TIMEOUT;
        r.fallback = `IOCFG_DEF_FALLBACK;
        r.debounce_en = `IOCFG_DEF_DEBOUNCE;
        r.rx_cnt = 32'h0000_0000;
        r.bad_cnt = 32'h0000_0000;
        r.tx_cnt = 32'h0000_0000;
        r.pulse1_lo = 16'h0000;
        r.outs = `IOCFG_DEF_FALLBACK;
        r.wd_cnt = 16'h0000;
        r.hold_busy = 1'b0;
        r.awaiting = 1'b0;
        r.led_cnt = 10'h000;
        clear_regs = r;
    endfunction

    always_comb begin
        n = st;
        n.ack = 1'b0;
        n.err = 1'b0;
        n.tx_start = 1'b0;
        n.wd_fire = 1'b0;
        n.ms_tick = 1'b0;
        // three-stage synchronisers, change taken once stages two and three agree
        n.sa1 = i_din;
        n.sa2 = st.sa1;
        n.sa3 = st.sa2;
        n.sw1 = i_switch;
        n.sw2 = st.sw1;
        n.sw3 = st.sw2;
        if (st.sa2 == st.sa3) begin
            n.din_stable = st.sa3;
        end
        if (st.sw2 == st.sw3) begin
            n.sw_stable = st.sw3; // [RULE12] [RULE21]
        end
        // millisecond prescaler
        if (st.ms_pre == CYC_PER_MS - 16'h0001) begin
            n.ms_pre = 16'h0000;
            n.ms_tick = 1'b1;
        end else begin
            n.ms_pre = st.ms_pre + 16'h0001;
        end
        // per-input debounce
        for (int i = 0; i < 8; i++) begin
            if (!st.debounce_en[i]) begin // [RULE14] [RULE19]
                n.filt[i] = st.din_stable[i];
                n.dbc_cnt[i] = 7'h00;
            end else if (st.din_stable[i] == st.filt[i]) begin
                n.dbc_cnt[i] = 7'h00;
            end else if (st.ms_tick) begin
                if (st.dbc_cnt[i] + 7'h01 >=
                        (st.din_stable[i] ? FILT_RISE_MS : FILT_FALL_MS)) begin
                    n.filt[i] = st.din_stable[i]; // [RULE13]
                    n.dbc_cnt[i] = 7'h00;
                end else begin
                    n.dbc_cnt[i] = st.dbc_cnt[i] + 7'h01;
                end
            end
        end
        // register reads
        if (i_req.rd) begin // [RULE18]
            n.ack = 1'b1;
            n.rdata = 16'h0000;
            unique case (i_req.addr)
                `IOCFG_ADDR_VERSION: n.rdata = VERSION_TYPE_ID; // [RULE17]
                `IOCFG_ADDR_SWITCH: n.rdata = {10'h000, st.sw_stable}; // [RULE21]
                `IOCFG_ADDR_RATE: n.rdata = st.rate_code;
                `IOCFG_ADDR_FRAMING: n.rdata = st.framing;
                `IOCFG_ADDR_PARITY: n.rdata = st.parity;
                `IOCFG_ADDR_HOLDOFF: n.rdata = st.holdoff;
                `IOCFG_ADDR_PROTO: n.rdata = st.proto;
                `IOCFG_ADDR_TIMEOUT: n.rdata = st.timeout;
                `IOCFG_ADDR_FALLBACK: n.rdata = st.fallback;
                `IOCFG_ADDR_DEBOUNCE: n.rdata = st.debounce_en;
                `IOCFG_ADDR_RX_LO: n.rdata = st.rx_cnt[15:0]; // [RULE16]
                `IOCFG_ADDR_RX_HI: n.rdata = st.rx_cnt[31:16];
                `IOCFG_ADDR_BAD_LO: n.rdata = st.bad_cnt[15:0];
                `IOCFG_ADDR_BAD_HI: n.rdata = st.bad_cnt[31:16];
                `IOCFG_ADDR_TX_LO: n.rdata = st.tx_cnt[15:0];
                `IOCFG_ADDR_TX_HI: n.rdata = st.tx_cnt[31:16];
                `IOCFG_ADDR_INPUTS: n.rdata = {8'h00, st.filt}; // [RULE19]
                `IOCFG_ADDR_OUTPUTS: n.rdata = st.outs;
                `IOCFG_ADDR_PULSE1_LO: n.rdata = st.pulse1_lo;
                default: n.err = 1'b1;
            endcase
        end else if (i_req.wr) begin
            // 16-bit words only; read-only offsets ignore the data
            n.ack = 1'b1;
            unique case (i_req.addr)
                `IOCFG_ADDR_VERSION, `IOCFG_ADDR_SWITCH, `IOCFG_ADDR_INPUTS: n.ack = 1'b1;
                `IOCFG_ADDR_RATE: n.rate_code = i_req.wdata;
                `IOCFG_ADDR_FRAMING: n.framing = i_req.wdata;
                `IOCFG_ADDR_PARITY: n.parity = i_req.wdata;
                `IOCFG_ADDR_HOLDOFF: n.holdoff = i_req.wdata;
                `IOCFG_ADDR_PROTO: n.proto = i_req.wdata;
                `IOCFG_ADDR_TIMEOUT: begin
                    n.timeout = i_req.wdata;
                    n.wd_cnt = i_req.wdata;
                end
                `IOCFG_ADDR_FALLBACK: n.fallback = i_req.wdata;
                `IOCFG_ADDR_DEBOUNCE: n.debounce_en = i_req.wdata;
                `IOCFG_ADDR_RX_LO: n.rx_cnt[15:0] = i_req.wdata;
                `IOCFG_ADDR_RX_HI: n.rx_cnt[31:16] = i_req.wdata;
                `IOCFG_ADDR_BAD_LO: n.bad_cnt[15:0] = i_req.wdata;
                `IOCFG_ADDR_BAD_HI: n.bad_cnt[31:16] = i_req.wdata;
                `IOCFG_ADDR_TX_LO: n.tx_cnt[15:0] = i_req.wdata;
                `IOCFG_ADDR_TX_HI: n.tx_cnt[31:16] = i_req.wdata;
                `IOCFG_ADDR_OUTPUTS: n.outs = i_req.wdata;
                `IOCFG_ADDR_PULSE1_LO: n.pulse1_lo = i_req.wdata;
                default: n.err = 1'b1;
            endcase
        end
        // packet statistics; an event on top of a write still counts
        if (i_pkt.rx_ok || i_pkt.rx_bad) begin
            n.rx_cnt = n.rx_cnt + 32'h0000_0001; // [RULE16]
        end
        if (i_pkt.rx_bad) begin
            n.bad_cnt = n.bad_cnt + 32'h0000_0001;
        end
        if (i_pkt.tx_done) begin
            n.tx_cnt = n.tx_cnt + 32'h0000_0001;
        end
        // watchdog
        if (n.timeout == 16'h0000) begin
            n.wd_cnt = 16'h0000; // [RULE9]
        end else if (i_pkt.rx_ok) begin
            n.wd_cnt = n.timeout; // [RULE20]
        end else if (st.ms_tick && st.wd_cnt != 16'h0000) begin
            n.wd_cnt = st.wd_cnt - 16'h0001;
            if (st.wd_cnt == 16'h0001) begin
                n.wd_fire = 1'b1; // [RULE8]
                n.outs = {8'h00, st.fallback[7:0]}; // [RULE15]
            end
        end
        // reply hold-off
        if (!st.hold_busy) begin
            if (i_pkt.reply_ready) begin
                if (st.holdoff == 16'h0000) begin
                    n.tx_start = 1'b1; // [RULE6]
                end else begin
                    n.hold_busy = 1'b1;
                    n.hold_ms = st.holdoff;
                    n.hold_sub = 16'h0000;
                end
            end
        end else if (st.hold_sub == CYC_PER_MS - 16'h0001) begin
            n.hold_sub = 16'h0000;
            n.hold_ms = st.hold_ms - 16'h0001;
            if (st.hold_ms == 16'h0001) begin
                n.hold_busy = 1'b0;
                n.tx_start = 1'b1; // [RULE6]
            end
        end else begin
            n.hold_sub = st.hold_sub + 16'h0001;
        end
        // communication indicator: good packet, then its reply sent
        if (i_pkt.rx_ok) begin
            n.awaiting = 1'b1;
        end else if (i_pkt.tx_done) begin
            n.awaiting = 1'b0;
        end
        if (i_pkt.tx_done && st.awaiting) begin
            n.led_cnt = LED_ON_MS; // [RULE10]
        end else if (st.ms_tick && st.led_cnt != 10'h000) begin
            n.led_cnt = st.led_cnt - 10'h001;
        end
        // decoded line settings
        n.baud_hz = rate_of(st.rate_code); // [RULE3]
        n.two_stop = st.framing[`IOCFG_FR_STOP_LSB +: 8] == 8'h02; // [RULE5]
        n.seven_bits = st.framing[`IOCFG_FR_DATA_LSB +: 8] == 8'h07; // [RULE5]
        // restore check once the switch synchroniser has settled
        if (st.chk != 3'(`IOCFG_RESTORE_CHK)) begin
            n.chk = st.chk + 3'h1;
        end else if (!st.restore_done && st.sw_stable[5]) begin
            n = clear_regs(n); // [RULE2]
            n.restore_done = 1'b1;
        end
        // lit during restore so the operator knows to open the switch
        n.comm_led = (n.led_cnt != 10'h000) || (n.restore_done && st.sw_stable[5]); // [RULE1]
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= clear_regs('0); // [RULE15]
        end else begin
            st <= n;
        end
    end

    assign o_reg_ack = st.ack;
    assign o_reg_err = st.err;
    assign o_reg_rdata = st.rdata;
    assign o_dout = st.outs[7:0]; // [RULE19]
    assign o_in_led = st.filt; // [RULE11]
    assign o_out_led = st.outs[7:0]; // [RULE11]
    assign o_comm_led = st.comm_led;
    assign o_module_addr = st.sw_stable[4:0]; // [RULE12]
    assign o_baud_hz = st.baud_hz;
    assign o_parity_mode = st.parity[2:0]; // [RULE4]
    assign o_two_stop = st.two_stop;
    assign o_seven_bits = st.seven_bits;
    assign o_ascii_mode = st.proto[0]; // [RULE7]
    assign o_tx_start = st.tx_start;
    assign o_restore_active = st.restore_done;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_rate_code_table: assert property (st.rate_code == 16'h0002 |=> // [RULE3]
        st.baud_hz == 20'd9600)
        else $error("rate code 2 not decoded to 9600");
    a_rate_times_ten: assert property (st.rate_code > 16'h0006 |=> // [RULE3]
        st.baud_hz == 20'($past(st.rate_code)) * 20'd10)
        else $error("other rate code not times ten");
    a_parity_write: assert property (i_req.wr && !i_req.rd // [RULE4]
        && i_req.addr == `IOCFG_ADDR_PARITY && i_req.wdata == 16'h0004
        |=> o_parity_mode == 3'h4)
        else $error("parity code not applied");
    a_framing_decode: assert property (st.framing == 16'h0702 |=> // [RULE5]
        o_two_stop && o_seven_bits)
        else $error("framing not decoded");
    a_holdoff_zero: assert property (i_pkt.reply_ready && !st.hold_busy // [RULE6]
        && st.holdoff == 16'h0000 |=> o_tx_start)
        else $error("reply without delay not started at once");
    a_holdoff_wait: assert property (i_pkt.reply_ready && !st.hold_busy // [RULE6]
        && st.holdoff != 16'h0000 |=> !o_tx_start [*3])
        else $error("reply started before hold-off");
    a_wdog_zero_quiet: assert property (st.timeout == 16'h0000 |=> !st.wd_fire) // [RULE9]
        else $error("watchdog fired while disabled");
    a_wdog_fallback: assert property (st.wd_fire |-> o_dout == $past(st.fallback[7:0])) // [RULE8]
        else $error("timeout did not apply fallback pattern");
    a_wdog_restart: assert property (i_pkt.rx_ok && !i_req.wr // [RULE20]
        && st.timeout != 16'h0000 |=> st.wd_cnt == $past(st.timeout))
        else $error("valid message did not restart watchdog");
    a_comm_led_cause: assert property ($rose(st.led_cnt != 10'h000) |-> // [RULE10]
        $past(i_pkt.tx_done) && $past(st.awaiting))
        else $error("comm indicator lit without reply");
    a_switch_address: assert property (st.sw2 == st.sw3 && $stable(st.sw3) |=> // [RULE12]
        o_module_addr == $past(st.sw3[4:0]))
        else $error("address not taken from switches");
    a_filter_bypass: assert property (!st.debounce_en[1] |=> // [RULE14]
        st.filt[1] == $past(st.din_stable[1]))
        else $error("unfiltered input not passed");
    a_filter_rise: assert property ($rose(st.filt[0]) && $past(st.debounce_en[0]) |-> // [RULE13]
        $past(st.dbc_cnt[0]) == FILT_RISE_MS - 7'h01)
        else $error("filtered input rose early");
    a_rx_count: assert property (i_pkt.rx_ok && !i_req.wr |=> // [RULE16]
        st.rx_cnt == $past(st.rx_cnt) + 32'h1)
        else $error("received packet not counted");
    a_version_read: assert property (i_req.rd && i_req.addr == `IOCFG_ADDR_VERSION |=> // [RULE17]
        o_reg_ack && o_reg_rdata == VERSION_TYPE_ID)
        else $error("version register wrong");
    a_restore_clear: assert property ($rose(st.restore_done) |-> st.rx_cnt == 32'h0 // [RULE2]
        && st.rate_code == `IOCFG_DEF_RATE && st.timeout == 16'h0000)
        else $error("restore left values behind");

    c_watchdog_fire: cover property (st.wd_fire);
    c_reply_delayed: cover property (st.hold_busy ##1 o_tx_start);
    c_comm_led_on: cover property ($rose(o_comm_led));
    c_restore: cover property ($rose(st.restore_done));

endmodule

/* File: verification/iocfg_master_model.sv */
// bus master model: sends packet events and answers the reply start
module iocfg_master_model (
    input wire logic i_clk,
    input wire logic i_tx_start,
    output iocfg_pkg::iocfg_pkt_t o_pkt
);
    timeunit 1ns;
    timeprecision 100ps;

    initial o_pkt = '0;

    // one request and its reply; cyc counts edges from reply_ready taken to tx start
    task automatic exchange(input logic bad, output int cyc);
        cyc = 0;
        @(posedge i_clk);
        o_pkt <= bad ? 4'b0100 : 4'b1000;
        @(posedge i_clk);
        o_pkt <= bad ? 4'b0000 : 4'b0001;
        if (!bad) begin
            @(posedge i_clk);
            o_pkt <= '0;
            // reply start stands one cycle: look just after each edge
            #1;
            cyc = 1;
            while (i_tx_start !== 1'b1 && cyc < 5000) begin
                @(posedge i_clk);
                #1;
                cyc++;
            end
            if (i_tx_start !== 1'b1) cyc = -1;
            @(posedge i_clk);
            o_pkt <= 4'b0010;
            @(posedge i_clk);
            o_pkt <= '0;
        end
    endtask
endmodule

/* File: verification/iocfg_regbank_tb_top.sv */
// testbench of the i/o configuration register bank
`include "iocfg_regs.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_fail++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, x); end end

module iocfg_regbank_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // arbitrary identification value
    localparam logic [15:0] VER = 16'h0A01;
    logic i_clk, i_rstn, ack, err, comm, two_stop, seven, ascii, tx_start, restored;
    iocfg_pkg::iocfg_req_t req;
    iocfg_pkg::iocfg_pkt_t pkt;
    logic [7:0] din, dout, in_led, out_led;
    logic [5:0] sw;
    logic [15:0] rdata, q;
    logic [4:0] maddr;
    logic [19:0] baud;
    logic [2:0] par;
    logic e;
    int n_fail, compares, cyc;
    logic [19:0] rates [7] = '{20'd2400, 20'd4800, 20'd9600, 20'd19200, 20'd38400,
                               20'd57600, 20'd115200};

    iocfg_regbank #(.VERSION_TYPE_ID(VER), .CYC_PER_MS(16'h0004), .FILT_RISE_MS(7'h04),
        .FILT_FALL_MS(7'h08), .LED_ON_MS(10'h005)) dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_req(req), .i_pkt(pkt), .i_din(din), .i_switch(sw), .o_reg_ack(ack),
        .o_reg_err(err), .o_reg_rdata(rdata), .o_dout(dout), .o_in_led(in_led),
        .o_out_led(out_led), .o_comm_led(comm), .o_module_addr(maddr), .o_baud_hz(baud),
        .o_parity_mode(par), .o_two_stop(two_stop), .o_seven_bits(seven),
        .o_ascii_mode(ascii), .o_tx_start(tx_start), .o_restore_active(restored));

    iocfg_master_model mdl (.i_clk(i_clk), .i_tx_start(tx_start), .o_pkt(pkt));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic test_done;
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic bus(input logic r, input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        req <= {r, ~r, a, d};
        @(posedge i_clk);
        req <= '0;
        #1;
        `CHK(ack, 1'b1)
        q = rdata;
        e = err;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus(1'b0, a, d);
        `CHK(e, 1'b0)
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] x);
        bus(1'b1, a, 16'h0000);
        `CHK(q, x)
    endtask

    task automatic run_x(input logic bad, input int x);
        mdl.exchange(bad, cyc);
        if (cyc < 0) begin
            n_fail++;
            test_done();
        end else if (!bad) begin
            `CHK(cyc, x)
        end
    endtask

    initial begin
        i_rstn = 1'b0;
        req = '0;
        din = 8'h00;
        sw = 6'h13;
        n_fail = 0;
        compares = 0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        tick(8);
        `CHK(maddr, 5'h13)
        rd_chk(`IOCFG_ADDR_SWITCH, 16'h0013);
        rd_chk(`IOCFG_ADDR_VERSION, VER);
        wr(`IOCFG_ADDR_VERSION, 16'hFFFF);
        rd_chk(`IOCFG_ADDR_VERSION, VER);
        rd_chk(`IOCFG_ADDR_TIMEOUT, 16'h0000);
        rd_chk(`IOCFG_ADDR_FRAMING, 16'h0801);
        bus(1'b1, 16'h0007, 16'h0000);
        `CHK({e, q}, 17'h10000)
        for (int i = 0; i < 8; i++) begin
            wr(`IOCFG_ADDR_RATE, (i == 7) ? 16'h0032 : 16'(i));
            tick(2);
            `CHK(baud, (i == 7) ? 20'd500 : rates[i])
        end
        for (int i = 0; i < 5; i++) begin
            wr(`IOCFG_ADDR_PARITY, 16'(i));
            tick(2);
            `CHK(par, 3'(i))
        end
        wr(`IOCFG_ADDR_FRAMING, 16'h0702);
        tick(2);
        `CHK({two_stop, seven}, 2'b11)
        wr(`IOCFG_ADDR_FRAMING, 16'h0801);
        wr(`IOCFG_ADDR_PROTO, 16'h0001);
        tick(2);
        `CHK({two_stop, seven, ascii}, 3'b001)
        wr(`IOCFG_ADDR_PROTO, 16'h0000);
        tick(2);
        `CHK({ascii, comm}, 2'b00)
        run_x(1'b0, 1);
        tick(2);
        `CHK(comm, 1'b1)
        wr(`IOCFG_ADDR_HOLDOFF, 16'h0003);
        run_x(1'b0, 13);
        wr(`IOCFG_ADDR_HOLDOFF, 16'h0000);
        run_x(1'b1, 0);
        wr(`IOCFG_ADDR_OUTPUTS, 16'h00A5);
        tick(1);
        `CHK({dout, out_led}, 16'hA5A5)
        wr(`IOCFG_ADDR_FALLBACK, 16'h003C);
        wr(`IOCFG_ADDR_OUTPUTS, 16'h0081);
        wr(`IOCFG_ADDR_TIMEOUT, 16'h0008);
        tick(20);
        `CHK(dout, 8'h81)
        run_x(1'b0, 1);
        tick(20);
        `CHK(dout, 8'h81)
        tick(40);
        `CHK({dout, out_led}, 16'h3C3C)
        wr(`IOCFG_ADDR_TIMEOUT, 16'h0000);
        wr(`IOCFG_ADDR_OUTPUTS, 16'h000F);
        tick(100);
        `CHK(dout, 8'h0F)
        rd_chk(`IOCFG_ADDR_RX_LO, 16'h0004);
        rd_chk(`IOCFG_ADDR_BAD_LO, 16'h0001);
        rd_chk(`IOCFG_ADDR_TX_LO, 16'h0003);
        wr(`IOCFG_ADDR_RX_HI, 16'h0001);
        rd_chk(`IOCFG_ADDR_RX_HI, 16'h0001);
        @(posedge i_clk) din <= 8'h5A;
        tick(6);
        `CHK(in_led, 8'h5A)
        rd_chk(`IOCFG_ADDR_INPUTS, 16'h005A);
        wr(`IOCFG_ADDR_DEBOUNCE, 16'h0001);
        @(posedge i_clk) din <= 8'h59;
        tick(8);
        `CHK(in_led, 8'h58)
        tick(30);
        `CHK(in_led, 8'h59)
        @(posedge i_clk) din <= 8'h5A;
        tick(20);
        `CHK(in_led, 8'h5B)
        tick(40);
        `CHK(in_led, 8'h5A)
        @(posedge i_clk) begin
            sw <= 6'h33;
            i_rstn <= 1'b0;
        end
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        // both writes land before the restore check and must be wiped
        wr(`IOCFG_ADDR_PARITY, 16'h0002);
        wr(`IOCFG_ADDR_RX_LO, 16'h0005);
        cyc = 0;
        while (comm !== 1'b1 && cyc < 200) begin
            tick(1);
            cyc++;
        end
        if (comm !== 1'b1) begin
            n_fail++;
            test_done();
        end
        @(posedge i_clk) sw <= 6'h13;
        tick(1);
        `CHK(restored, 1'b1)
        rd_chk(`IOCFG_ADDR_PARITY, 16'h0000);
        rd_chk(`IOCFG_ADDR_RX_LO, 16'h0000);
        rd_chk(`IOCFG_ADDR_OUTPUTS, 16'h0000);
        test_done();
    end
endmodule
